// [hdl/mic_pkg.sv]
// constants for the measurement initiation control block
// Operation
// [RULE1] fail-stop on: limit failure clears continuous run; off: flag kept
// [RULE2] fail-stop acts only with limit testing on and continuous run set
// [RULE3] continuous run clear: no measurement until set or single initiate
// [RULE4] setting continuous run starts one; each completion starts next
// [RULE5] continuous start invalidates stats, zeroes count, flags no-stats bit 8
// [RULE6] auto-clear on: starts clear limit data, counts, annunciator, output
// [RULE7] auto trigger level on: auto-trigger on start and each cycle
// [RULE8] continuous run ignores block count, acts as count of one
// [RULE9] continuous pending set at first start, cleared by abort or last done
// [RULE10] abort in continuous run keeps flag; new measurement follows
// [RULE11] single in progress: continuous start -213, continuous stop -210
// [RULE12] continuous run set at power-up, cleared by command reset
// [RULE13] single starts block only with auto count, stats, normal function
// [RULE14] block start first clears statistics results and count
// [RULE15] single initiate while busy or continuous: ignored, error -213
// [RULE16] single pending set at start, cleared at completion or abort
// [RULE17] controller aborts an auto-armed totalize started by single initiate; nothing aborts it here except the abort command
// [RULE18] read is initiate plus fetch; measure adds configure; fetch repeatable
// [RULE19] unexpected parameter: command runs, command warning bit set
// [RULE20] fetch with no valid result raises error -230
// [RULE21] command reset clears fail-stop; on/off queries give ascii 0 or 1
package mic_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_ERR = 8'h0c;
  localparam logic [7:0] A_SCNT = 8'h10;
  localparam logic [7:0] A_LCNT = 8'h14;
  localparam logic [7:0] A_BLK = 8'h18;
  localparam logic [7:0] A_QRY = 8'h1c;
  localparam int C_CONT = 0, C_FSTOP = 1, C_ABLK = 2, C_STAT = 3;
  localparam int C_LIM = 4, C_LCLR = 5, C_ATRG = 6, C_FUNC = 8;
  localparam int K_CONTON = 0, K_CONTOFF = 1, K_INIT = 2, K_ABORT = 3;
  localparam int K_READ = 4, K_MEAS = 5, K_FETCH = 6, K_XPARAM = 7, K_RST = 8;
  localparam int S_PEND = 0, S_RUN = 1, S_RVALID = 2, S_SVALID = 3;
  localparam int S_LFAIL = 4, S_LANN = 5, S_LOUT = 6, S_CWARN = 7, S_NOSTAT = 8;
  localparam logic [2:0] FUNC_TOT = 3'h1;
  localparam logic [2:0] FUNC_VMAX = 3'h2;
  localparam logic [2:0] FUNC_VPP = 3'h4;
  localparam logic [15:0] ERR_INIT_IGN = 16'hff2b;
  localparam logic [15:0] ERR_TRIG = 16'hff2e;
  localparam logic [15:0] ERR_STALE = 16'hff1a;
  localparam logic [15:0] BLK_RST = 16'h0064;
  localparam logic [7:0] CHAR_0 = 8'h30;
  localparam logic [2:0] SZ_WORD = 3'h2;
  typedef enum logic [1:0] {MIC_IDLE = 2'b01, MIC_RUN = 2'b10} mic_state_type;
endpackage

// [hdl/mic_ahb_slave.sv]
// ahb-lite slave front end: one wait state on reads, none on writes
`timescale 1ns/1ps
`default_nettype none
module mic_ahb_slave
  import mic_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] rdData,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic wrEn,
  output logic rdEn,
  output logic [7:0] addr
);
  logic wr_q, wr_d, rd_q, rd_d, rdy_q, rdy_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] rdat_q, rdat_d;
  logic take;
  assign take = hsel && htrans[1] && hready;
  always_comb begin
    wr_d = take && hwrite && (hsize == SZ_WORD);
    rd_d = take && !hwrite;
    addr_d = take ? haddr[7:0] : addr_q;
    // read data must come from a flop, so stall one cycle
    rdy_d = !(take && !hwrite);
    rdat_d = (rd_q && !rdy_q) ? rdData : rdat_q;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdy_q <= 1'b1;
      addr_q <= '0;
      rdat_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      addr_q <= addr_d;
      rdat_q <= rdat_d;
    end
  end
  assign hreadyout = rdy_q;
  assign hresp = 1'b0;
  assign hrdata = rdat_q;
  assign wrEn = wr_q;
  assign rdEn = rd_q && !rdy_q;
  assign addr = addr_q;
endmodule
`default_nettype wire

// [hdl/mic_err_log.sv]
// last error code and count, popped by a read
`timescale 1ns/1ps
`default_nettype none
module mic_err_log (
  input wire logic clk,
  input wire logic srst,
  input wire logic push,
  input wire logic [15:0] code,
  input wire logic pop,
  output logic [15:0] lastCode,
  output logic [7:0] count
);
  logic [15:0] code_q, code_d;
  logic [7:0] cnt_q, cnt_d;
  always_comb begin
    code_d = code_q;
    cnt_d = cnt_q;
    if (pop) begin
      code_d = '0;
      cnt_d = '0;
    end
    // a new error wins over the pop in the same cycle
    if (push) begin
      code_d = code;
      cnt_d = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
      if (pop) cnt_d = 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      code_q <= '0;
      cnt_q <= '0;
    end else begin
      code_q <= code_d;
      cnt_q <= cnt_d;
    end
  end
  assign lastCode = code_q;
  assign count = cnt_q;
endmodule
`default_nettype wire

// [hdl/mic_top.sv]
// measurement initiation control with ahb-lite registers
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mic_top
  import mic_pkg::*;
#(
  parameter logic [15:0] BLOCK_DEFAULT = BLK_RST
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic measDone,
  input wire logic measLimitFail,
  output logic measStart,
  output logic measAbort,
  output logic autoTrigger,
  output logic configure,
  output logic fetchStrobe,
  output logic fetchNoData,
  output logic pendingOp,
  output logic limitOutLevel,
  output logic limitAnnunciator,
  output logic opNotStats,
  output logic questCmdWarn
);
  import mic_pkg::*;
  logic wrEn, rdEn, cmdWr, fetchNow, isBlock, busy, errPush, doneFail;
  logic [7:0] rAddr;
  logic [31:0] rdData;
  logic [15:0] errCode, errLast;
  logic [7:0] errCnt;
  mic_state_type state_q, state_d;
  logic contRun_q, contRun_d, failStop_q, failStop_d;
  logic autoBlk_q, autoBlk_d, statEn_q, statEn_d;
  logic limEn_q, limEn_d, limAuto_q, limAuto_d;
  logic autoTrg_q, autoTrg_d, single_q, single_d;
  logic [2:0] func_q, func_d;
  logic [15:0] blkSize_q, blkSize_d, blkLeft_q, blkLeft_d;
  logic [15:0] statCnt_q, statCnt_d, failCnt_q, failCnt_d;
  logic [15:0] passCnt_q, passCnt_d;
  logic pend_q, pend_d, rValid_q, rValid_d, sValid_q, sValid_d;
  logic noStat_q, noStat_d, cWarn_q, cWarn_d, lFail_q, lFail_d;
  logic lAnn_q, lAnn_d, lOut_q, lOut_d, fWait_q, fWait_d;
  logic start_q, start_d, abort_q, abort_d, trig_q, trig_d;
  logic cfg_q, cfg_d, fStr_q, fStr_d, fNone_q, fNone_d;

  mic_ahb_slave u_bus (
    .clk(clk),
    .srst(srst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .rdData(rdData),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wrEn(wrEn),
    .rdEn(rdEn),
    .addr(rAddr)
  );

  mic_err_log u_err (
    .clk(clk),
    .srst(srst),
    .push(errPush),
    .code(errCode),
    .pop(rdEn && rAddr == A_ERR),
    .lastCode(errLast),
    .count(errCnt)
  );

  assign cmdWr = wrEn && rAddr == A_CMD;
  // a fail landing in the cycle of a continuous start keeps its flags: the set wins; a single initiate clears them
  assign doneFail = state_q == MIC_RUN && measDone && limEn_q && measLimitFail;
  // totalize and voltage peaks never run as a block; measure turns stats off first
  assign isBlock = autoBlk_q && statEn_q && !(cmdWr && hwdata[K_MEAS]) && func_q != FUNC_TOT &&
    !(func_q >= FUNC_VMAX && func_q <= FUNC_VPP); // RULE13

  always_comb begin
    rdData = '0;
    unique case (rAddr)
      A_CTRL: begin
        rdData[C_CONT] = contRun_q;
        rdData[C_FSTOP] = failStop_q;
        rdData[C_ABLK] = autoBlk_q;
        rdData[C_STAT] = statEn_q;
        rdData[C_LIM] = limEn_q;
        rdData[C_LCLR] = limAuto_q;
        rdData[C_ATRG] = autoTrg_q;
        rdData[C_FUNC +: 3] = func_q;
      end
      A_STAT: begin
        rdData[S_PEND] = pend_q;
        rdData[S_RUN] = state_q == MIC_RUN;
        rdData[S_RVALID] = rValid_q;
        rdData[S_SVALID] = sValid_q;
        rdData[S_LFAIL] = lFail_q;
        rdData[S_LANN] = lAnn_q;
        rdData[S_LOUT] = lOut_q;
        rdData[S_CWARN] = cWarn_q;
        rdData[S_NOSTAT] = noStat_q;
      end
      A_ERR: rdData = {8'h00, errCnt, errLast};
      A_SCNT: rdData = {16'h0000, statCnt_q};
      A_LCNT: rdData = {passCnt_q, failCnt_q};
      A_BLK: rdData = {16'h0000, blkSize_q};
      A_QRY: rdData = {16'h0000, CHAR_0 | {7'h00, failStop_q},
        CHAR_0 | {7'h00, contRun_q}}; // RULE21
      default: rdData = '0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    contRun_d = contRun_q;
    failStop_d = failStop_q;
    autoBlk_d = autoBlk_q;
    statEn_d = statEn_q;
    limEn_d = limEn_q;
    limAuto_d = limAuto_q;
    autoTrg_d = autoTrg_q;
    func_d = func_q;
    single_d = single_q;
    blkSize_d = blkSize_q;
    blkLeft_d = blkLeft_q;
    statCnt_d = statCnt_q;
    failCnt_d = failCnt_q;
    passCnt_d = passCnt_q;
    pend_d = pend_q;
    rValid_d = rValid_q;
    sValid_d = sValid_q;
    noStat_d = noStat_q;
    cWarn_d = cWarn_q;
    lFail_d = lFail_q;
    lAnn_d = lAnn_q;
    lOut_d = lOut_q;
    fWait_d = fWait_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    trig_d = 1'b0;
    cfg_d = 1'b0;
    fStr_d = 1'b0;
    fNone_d = fNone_q;
    fetchNow = 1'b0;
    busy = 1'b0;
    errPush = 1'b0;
    errCode = '0;
    if (wrEn && rAddr == A_CTRL) begin
      failStop_d = hwdata[C_FSTOP];
      autoBlk_d = hwdata[C_ABLK];
      statEn_d = hwdata[C_STAT];
      limEn_d = hwdata[C_LIM];
      limAuto_d = hwdata[C_LCLR];
      autoTrg_d = hwdata[C_ATRG];
      func_d = hwdata[C_FUNC +: 3];
    end
    if (wrEn && rAddr == A_BLK) begin
      blkSize_d = hwdata[15:0];
    end
    if (rdEn && rAddr == A_STAT) begin
      cWarn_d = 1'b0;
    end
    if (state_q == MIC_RUN && measDone) begin
      rValid_d = 1'b1;
      if (statEn_q) begin
        statCnt_d = statCnt_q + 16'h0001;
        sValid_d = 1'b1;
        noStat_d = 1'b0;
      end
      if (limEn_q) begin
        if (measLimitFail) begin
          failCnt_d = failCnt_q + 16'h0001;
          lFail_d = 1'b1;
          lAnn_d = 1'b1;
          lOut_d = 1'b1;
          if (failStop_q && contRun_q && !single_q) begin
            contRun_d = 1'b0; // RULE1 RULE2
          end
        end else begin
          passCnt_d = passCnt_q + 16'h0001;
        end
      end
      if (single_q && blkLeft_q > 16'h0001) begin
        blkLeft_d = blkLeft_q - 16'h0001;
        start_d = 1'b1;
      end else if (!single_q && contRun_d) begin
        start_d = 1'b1; // RULE4 RULE8
        trig_d = autoTrg_q; // RULE7
        // a fetch held during continuous run is answered by this result
        fetchNow = fWait_q;
        fWait_d = 1'b0;
      end else begin
        state_d = MIC_IDLE;
        pend_d = 1'b0; // RULE9 RULE16
        fetchNow = fWait_q;
        fWait_d = 1'b0;
      end
    end
    if (cmdWr) begin
      if (hwdata[K_XPARAM]) begin
        cWarn_d = 1'b1; // RULE19
      end
      if (hwdata[K_RST]) begin
        contRun_d = 1'b0; // RULE12
        failStop_d = 1'b0; // RULE21
        autoBlk_d = 1'b0;
        statEn_d = 1'b0;
        limEn_d = 1'b0;
        limAuto_d = 1'b0;
        autoTrg_d = 1'b0;
      end else begin
        if (hwdata[K_ABORT] && state_q == MIC_RUN) begin
          // abort never touches the continuous flag
          abort_d = 1'b1; // RULE10
          start_d = 1'b0;
          trig_d = 1'b0;
          state_d = MIC_IDLE;
          pend_d = 1'b0; // RULE9 RULE16
          fWait_d = 1'b0;
        end
        busy = state_d == MIC_RUN;
        if (hwdata[K_MEAS]) begin
          cfg_d = 1'b1; // RULE18
          statEn_d = 1'b0;
          limEn_d = 1'b0;
        end
        if (hwdata[K_CONTON]) begin
          if (busy && single_q) begin
            errPush = 1'b1; // RULE11
            errCode = ERR_INIT_IGN;
          end else begin
            contRun_d = 1'b1;
            sValid_d = 1'b0; // RULE5
            statCnt_d = '0;
            noStat_d = 1'b1;
            trig_d = autoTrg_q; // RULE7
            if (limAuto_q) begin
              lFail_d = doneFail; // RULE6
              failCnt_d = '0;
              passCnt_d = '0;
              lAnn_d = doneFail;
              lOut_d = doneFail;
            end
          end
        end
        if (hwdata[K_CONTOFF]) begin
          if (busy && single_q) begin
            errPush = 1'b1; // RULE11
            errCode = ERR_TRIG;
          end else begin
            contRun_d = 1'b0;
          end
        end
        if (hwdata[K_INIT] || hwdata[K_READ] || hwdata[K_MEAS]) begin
          if (busy || contRun_d) begin
            errPush = 1'b1; // RULE15
            errCode = ERR_INIT_IGN;
            fetchNow = hwdata[K_READ] || hwdata[K_MEAS];
          end else begin
            state_d = MIC_RUN;
            single_d = 1'b1;
            pend_d = 1'b1; // RULE16
            start_d = 1'b1; // RULE3
            trig_d = autoTrg_q; // RULE7
            rValid_d = 1'b0;
            blkLeft_d = isBlock ? blkSize_q : 16'h0001; // RULE13
            fWait_d = hwdata[K_READ] || hwdata[K_MEAS]; // RULE18
            if (isBlock) begin
              sValid_d = 1'b0; // RULE14
              statCnt_d = '0;
            end
            if (limAuto_q) begin
              lFail_d = 1'b0; // RULE6
              failCnt_d = '0;
              passCnt_d = '0;
              lAnn_d = 1'b0;
              lOut_d = 1'b0;
            end
          end
        end
        if (hwdata[K_FETCH]) begin
          if (state_d == MIC_RUN) begin
            fWait_d = 1'b1;
          end else begin
            fetchNow = 1'b1;
          end
        end
      end
    end
    if (state_d == MIC_IDLE && contRun_d && !(cmdWr && hwdata[K_ABORT])) begin
      // idle with the flag set means the next cycle must start
      state_d = MIC_RUN;
      single_d = 1'b0;
      pend_d = 1'b1; // RULE9
      start_d = 1'b1; // RULE4
      trig_d = autoTrg_q; // RULE7
    end
    if (fetchNow) begin
      // fetch never consumes the result, so it may repeat
      fStr_d = 1'b1; // RULE18
      fNone_d = !rValid_d;
      if (!rValid_d) begin
        errPush = 1'b1; // RULE20
        errCode = ERR_STALE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= MIC_IDLE;
      contRun_q <= 1'b1; // RULE12
      failStop_q <= 1'b0;
      autoBlk_q <= 1'b0;
      statEn_q <= 1'b0;
      limEn_q <= 1'b0;
      limAuto_q <= 1'b0;
      autoTrg_q <= 1'b0;
      func_q <= '0;
      single_q <= 1'b0;
      blkSize_q <= BLOCK_DEFAULT;
      blkLeft_q <= '0;
      statCnt_q <= '0;
      failCnt_q <= '0;
      passCnt_q <= '0;
      pend_q <= 1'b0;
      rValid_q <= 1'b0;
      sValid_q <= 1'b0;
      noStat_q <= 1'b1;
      cWarn_q <= 1'b0;
      lFail_q <= 1'b0;
      lAnn_q <= 1'b0;
      lOut_q <= 1'b0;
      fWait_q <= 1'b0;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      trig_q <= 1'b0;
      cfg_q <= 1'b0;
      fStr_q <= 1'b0;
      fNone_q <= 1'b0;
    end else begin
      state_q <= state_d;
      contRun_q <= contRun_d;
      failStop_q <= failStop_d;
      autoBlk_q <= autoBlk_d;
      statEn_q <= statEn_d;
      limEn_q <= limEn_d;
      limAuto_q <= limAuto_d;
      autoTrg_q <= autoTrg_d;
      func_q <= func_d;
      single_q <= single_d;
      blkSize_q <= blkSize_d;
      blkLeft_q <= blkLeft_d;
      statCnt_q <= statCnt_d;
      failCnt_q <= failCnt_d;
      passCnt_q <= passCnt_d;
      pend_q <= pend_d;
      rValid_q <= rValid_d;
      sValid_q <= sValid_d;
      noStat_q <= noStat_d;
      cWarn_q <= cWarn_d;
      lFail_q <= lFail_d;
      lAnn_q <= lAnn_d;
      lOut_q <= lOut_d;
      fWait_q <= fWait_d;
      start_q <= start_d;
      abort_q <= abort_d;
      trig_q <= trig_d;
      cfg_q <= cfg_d;
      fStr_q <= fStr_d;
      fNone_q <= fNone_d;
    end
  end

  assign measStart = start_q;
  assign measAbort = abort_q;
  assign autoTrigger = trig_q;
  assign configure = cfg_q;
  assign fetchStrobe = fStr_q;
  assign fetchNoData = fNone_q;
  assign pendingOp = pend_q;
  assign limitOutLevel = lOut_q;
  assign limitAnnunciator = lAnn_q;
  assign opNotStats = noStat_q;
  assign questCmdWarn = cWarn_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic runFail;
  assign runFail = state_q == MIC_RUN && !single_q && measDone && !cmdWr;
  a_fail_stop: assert property (runFail && limEn_q && failStop_q && measLimitFail
    |=> !contRun_q) else $error("fail-stop did not clear run flag"); // RULE1
  a_stop_inert: assert property (runFail && !limEn_q
    |=> $stable(contRun_q)) else $error("run flag moved without limit test"); // RULE2
  a_start_cause: assert property (measStart
    |-> $past(contRun_q || single_q || cmdWr)) else $error("start without cause"); // RULE3
  a_cont_next: assert property (runFail && contRun_q && !measLimitFail
    |=> measStart ##1 !measStart) else $error("no restart"); // RULE4
  a_cont_stats: assert property (cmdWr && hwdata[K_CONTON] && !hwdata[K_RST] && state_q == MIC_IDLE
    |=> statCnt_q == 16'h0000 && opNotStats) else $error("stats not reset"); // RULE5
  a_cont_pend: assert property (runFail && !contRun_q
    |=> !pendingOp) else $error("pending not cleared"); // RULE9
  a_init_busy: assert property (cmdWr && hwdata[K_INIT] && !hwdata[K_RST] && !hwdata[K_ABORT]
    && !hwdata[K_CONTOFF] && contRun_q |-> errPush) else $error("init not refused"); // RULE15
  a_single_pend: assert property (state_q == MIC_RUN && single_q
    |-> pendingOp) else $error("pending low during single"); // RULE16
  a_cmd_reset: assert property (cmdWr && hwdata[K_RST]
    |=> (!contRun_q && !failStop_q) [*2]) else $error("reset left flags"); // RULE12
  a_stale_err: assert property (fetchStrobe && fetchNoData
    |-> $past(errPush && errCode == ERR_STALE)) else $error("stale fetch no error"); // RULE20
  a_warn_set: assert property (cmdWr && hwdata[K_XPARAM]
    |=> questCmdWarn) else $error("command warning not set"); // RULE19
endmodule
`default_nettype wire

// [tb/mic_meas_model.sv]
// measurement engine model on the far side of the initiation control
`timescale 1ns/1ps
`default_nettype none
module mic_meas_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic measStart,
  input wire logic measAbort,
  input wire logic failNext,
  input wire logic [7:0] delay,
  output logic measDone,
  output logic measLimitFail
);
  logic busy;
  logic noise;
  logic [7:0] left;
  always_ff @(posedge clk) begin
    measDone <= 1'b0;
    noise <= ~noise;
    if (srst) begin
      busy <= 1'b0;
      noise <= 1'b0;
    end else if (measAbort) begin
      busy <= 1'b0; // an aborted measurement never reports done
    end else if (measStart) begin
      busy <= 1'b1;
      left <= delay;
    end else if (busy) begin
      if (left == 8'h00) begin
        busy <= 1'b0;
        measDone <= 1'b1;
      end else begin
        left <= left - 8'h01;
      end
    end
  end
  // the fail line only means something beside done; between results it wanders
  assign measLimitFail = measDone ? failNext : noise;
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking testbench for the measurement initiation control
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mic_pkg::*;
  logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, failNext = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = SZ_WORD;
  logic [7:0] delay = 8'h14;
  wire logic hready, hreadyout, hresp, measDone, measLimitFail, measStart, measAbort, autoTrigger;
  wire logic configure, fetchStrobe, fetchNoData, pendingOp, limitOutLevel, limitAnnunciator;
  wire logic opNotStats, questCmdWarn;
  wire logic [31:0] hrdata;
  int failures = 0, compares = 0, starts = 0, trigs = 0, fetches = 0, s0, f0, t0;
  logic lastNoData = 1'b0;
  assign hready = hreadyout;
  mic_top dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .measDone(measDone), .measLimitFail(measLimitFail), .measStart(measStart),
    .measAbort(measAbort), .autoTrigger(autoTrigger), .configure(configure),
    .fetchStrobe(fetchStrobe), .fetchNoData(fetchNoData), .pendingOp(pendingOp),
    .limitOutLevel(limitOutLevel), .limitAnnunciator(limitAnnunciator), .opNotStats(opNotStats),
    .questCmdWarn(questCmdWarn));
  mic_meas_model engine (.clk(clk), .srst(srst), .measStart(measStart), .measAbort(measAbort),
    .failNext(failNext), .delay(delay), .measDone(measDone), .measLimitFail(measLimitFail));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (measStart === 1'b1) starts++;
    if (autoTrigger === 1'b1) trigs++;
    if (fetchStrobe === 1'b1) begin
      fetches++;
      lastNoData = fetchNoData;
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= SZ_WORD;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata; // read data is taken at the edge that ends the data phase
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic cmd(input int k);
    wr(A_CMD, 32'h1 << k);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bounded wait: the engine delay never exceeds a few hundred cycles here
  task automatic wait_pend(input logic v);
    repeat (600) if (pendingOp !== v) @(posedge clk);
  endtask
  task automatic done(input string n);
    $display("test %s ended at %0t", n, $time);
  endtask
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    cyc(20000);
    failures++;
    stop_test();
  end
  initial begin
    cyc(3);
    srst <= 1'b0;
    @(posedge clk);
    // a fetch during the power-up run waits for that run's result
    cmd(K_FETCH);
    cyc(30);
    chk({31'h0, lastNoData}, 32'h0);
    chk(fetches, 32'h1);
    ok(pendingOp === 1'b1);
    rd(A_QRY);
    chk({16'h0, q[15:0]}, 32'h3031);
    done("powerup");
    delay <= 8'h03;
    s0 = starts;
    cyc(60);
    ok(starts > s0 + 3);
    s0 = starts;
    cmd(K_ABORT);
    cyc(10);
    ok(starts > s0 && pendingOp === 1'b1);
    rd(A_QRY);
    chk({24'h0, q[7:0]}, {24'h0, CHAR_0 | 8'h01});
    cmd(K_INIT);
    rd(A_ERR);
    chk(q[23:0], {8'h01, ERR_INIT_IGN});
    done("continuous");
    wr(A_CTRL, 32'h10);
    failNext <= 1'b1;
    cyc(20);
    rd(A_QRY);
    chk({16'h0, q[15:0]}, 32'h3031);
    ok(limitOutLevel === 1'b1);
    wr(A_CTRL, 32'h12);
    cyc(20);
    rd(A_QRY);
    chk({16'h0, q[15:0]}, 32'h3130);
    wait_pend(1'b0);
    ok(pendingOp === 1'b0);
    s0 = starts;
    cyc(30);
    ok(starts == s0);
    done("failstop");
    cmd(K_RST);
    rd(A_QRY);
    chk({16'h0, q[15:0]}, 32'h3030);
    rd(A_CTRL);
    chk(q, 32'h0);
    cmd(K_XPARAM);
    @(posedge clk);
    ok(questCmdWarn === 1'b1);
    rd(A_STAT);
    ok(q[S_CWARN] === 1'b1);
    done("reset");
    delay <= 8'h1e;
    wr(A_CTRL, 32'h70);
    t0 = trigs;
    s0 = starts;
    cmd(K_INIT);
    @(posedge clk);
    ok(pendingOp === 1'b1);
    cmd(K_INIT);
    rd(A_ERR);
    chk(q[23:0], {8'h01, ERR_INIT_IGN});
    cmd(K_CONTON);
    rd(A_ERR);
    chk(q[23:0], {8'h01, ERR_INIT_IGN});
    rd(A_QRY);
    chk({24'h0, q[7:0]}, {24'h0, CHAR_0});
    cmd(K_CONTOFF);
    rd(A_ERR);
    chk(q[23:0], {8'h01, ERR_TRIG});
    wait_pend(1'b0);
    ok(pendingOp === 1'b0 && starts == s0 + 1);
    ok(trigs > t0);
    @(posedge clk);
    ok(limitOutLevel === 1'b1);
    cmd(K_INIT);
    @(posedge clk);
    ok(limitOutLevel === 1'b0 && limitAnnunciator === 1'b0);
    rd(A_LCNT);
    chk(q, 32'h0);
    wait_pend(1'b0);
    done("single");
    f0 = fetches;
    cmd(K_FETCH);
    cmd(K_FETCH);
    cyc(2);
    ok(fetches == f0 + 2 && lastNoData === 1'b0);
    s0 = starts;
    cmd(K_READ);
    cyc(2);
    wait_pend(1'b0);
    cyc(3);
    ok(starts == s0 + 1 && fetches > f0 + 2 && lastNoData === 1'b0);
    cmd(K_MEAS);
    @(posedge clk);
    ok(configure === 1'b1 && pendingOp === 1'b1);
    wait_pend(1'b0);
    rd(A_CTRL);
    chk(q, 32'h60);
    done("fetch");
    delay <= 8'h03;
    failNext <= 1'b0;
    wr(A_BLK, 32'h3);
    wr(A_CTRL, 32'h2c);
    for (int n = 0; n < 2; n++) begin
      s0 = starts;
      cmd(K_INIT);
      cyc(2);
      wait_pend(1'b0);
      ok(starts == s0 + 3);
    end
    rd(A_SCNT);
    chk(q, 32'h3);
    done("block");
    cmd(K_CONTON);
    @(posedge clk);
    ok(opNotStats === 1'b1);
    rd(A_SCNT);
    chk(q, 32'h0);
    rd(A_STAT);
    ok(q[S_SVALID] === 1'b0 && q[S_NOSTAT] === 1'b1);
    cmd(K_RST);
    wait_pend(1'b0);
    done("contstats");
    delay <= 8'hc8;
    wr(A_CTRL, 32'h10c);
    s0 = starts;
    cmd(K_INIT);
    cyc(10);
    ok(starts == s0 + 1 && pendingOp === 1'b1);
    cmd(K_ABORT);
    @(posedge clk);
    ok(measAbort === 1'b1);
    @(posedge clk);
    ok(pendingOp === 1'b0);
    cmd(K_FETCH);
    cyc(2);
    chk({31'h0, lastNoData}, 32'h1);
    rd(A_ERR);
    chk(q[23:0], {8'h01, ERR_STALE});
    done("totalize");
    stop_test();
  end
endmodule
`default_nettype wire
